// ### rdb_pkg.sv
// Shared constants of the RAM-disk bus port: timing, port map, config layout.
// Assumes a 20 MHz system clock; used by every rdb_* module except the host model.
package rdb_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS    = 50;
  localparam int REF_INTERVAL_NS  = 15600;
  localparam int REF_INTERVAL_CYC = REF_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int REF_LEN_NS       = 200;
  localparam int REF_LEN_CYC      = (REF_LEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NORMAL_WAITS     = 2;
  // ----------------------------------------
  // Host port block
  // ----------------------------------------
  localparam int         PORT_COUNT   = 4;
  localparam logic [1:0] PORT_DATA    = 2'h0;
  localparam logic [1:0] PORT_ADDR_HI = 2'h1;
  localparam logic [1:0] PORT_ADDR_LO = 2'h2;
  localparam logic [1:0] PORT_BOARD   = 2'h3;
  localparam int         WP_BIT       = 6;
  // ----------------------------------------
  // APB map and fields
  // ----------------------------------------
  localparam logic [7:0]  CFG_OFS       = 8'h00;
  localparam logic [7:0]  STAT_OFS      = 8'h04;
  localparam int          CFG_BASE_LSB  = 0;
  localparam int          CFG_BOARD_LSB = 8;
  localparam int          CFG_WPEN_BIT  = 16;
  localparam int          CFG_ADV_BIT   = 17;
  localparam int          CFG_EXT_BIT   = 18;
  localparam int          CFG_POL_BIT   = 19;
  localparam int          CFG_LINE_LSB  = 20;
  localparam logic [31:0] CFG_RESET     = 32'h0001_FE34;
  localparam logic [31:0] CFG_MASK      = 32'h003F_FF3F;
  localparam int          ST_LOCK_BIT   = 0;
  localparam int          ST_SEL_BIT    = 1;
  localparam int          ST_WP_BIT     = 2;
  localparam int          ST_REF_BIT    = 3;
  localparam int          ST_HI_LSB     = 8;
  localparam int          ST_LO_LSB     = 16;
  localparam int          ST_BOARD_LSB  = 24;
  localparam logic [1:0]  REF_LINE_NONE = 2'h3;
  // Ready sequencer states, Gray along idle-wait-done
  typedef enum logic [1:0]
  {
    RDB_IDLE = 2'h0,
    RDB_WAIT = 2'h1,
    RDB_DONE = 2'h3,
    RDB_LOCK = 2'h2
  } rdb_state_t;
endpackage

// ### rdb_port_decode.sv
// Address block and board-number decode for the host I/O port block.
// Assumes host address and switch inputs synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module rdb_port_decode
(
  // Host address
  input  wire logic [7:0] hostAddr,
  // Switches, open reads as one
  input  wire logic [5:0] baseSwitch,
  input  wire logic [7:0] boardSwitch,
  input  wire logic [2:0] boardNum,
  // Decode results
  output logic            inBlock,
  output logic            boardSel,
  output logic [1:0]      portSel
);
  import rdb_pkg::*;
  // Closed switch demands a zero, open a one on A7..A2
  assign inBlock  = (hostAddr[7:2] == baseSwitch);
  // Only the position that is closed enables this board
  assign boardSel = ~boardSwitch[boardNum];
  assign portSel  = hostAddr[1:0];
endmodule
`default_nettype wire

// ### rdb_ready_gen.sv
// Ready sequencer for data-port transfers plus the DRAM refresh scheduler.
// Assumes the host holds its request until ready is seen.
`timescale 1ns/1ps
`default_nettype none
module rdb_ready_gen
#(
  parameter int REF_INTERVAL = rdb_pkg::REF_INTERVAL_CYC
)
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic hostReset,
  // Transfer request
  input  wire logic req,
  input  wire logic dataReq,
  input  wire logic advanced,
  input  wire logic lockReq,
  // Refresh control
  input  wire logic refExt,
  input  wire logic refStrobe,
  // Results
  output logic      ready,
  output logic      locked,
  output logic      refBusy,
  output logic      xferActive
);
  import rdb_pkg::*;
  localparam int TW = $clog2(REF_INTERVAL + 1);
  localparam int RW = $clog2(REF_LEN_CYC + 1);
  localparam logic [TW-1:0] TMR_LAST = TW'(REF_INTERVAL - 1);
  localparam logic [RW-1:0] REF_LOAD = RW'(REF_LEN_CYC);
  localparam logic [1:0]    WAIT_LD  = 2'(NORMAL_WAITS - 1);

  rdb_state_t    state_r, state_nxt;
  logic [1:0]    cnt_r, cnt_nxt;
  logic [TW-1:0] tmr_r;
  logic [RW-1:0] refCnt_r;
  logic          strobePrev_r;
  logic          prevDone_r;
  wire           stall    = refBusy & ~refExt;
  wire           intStart = ~refExt & (tmr_r == TMR_LAST);
  wire           extStart = refExt & refStrobe & ~strobePrev_r;
  wire           refStart = intStart | extStart;
  wire           fastOk   = advanced & ~stall & ~lockReq;
  wire           dataDone = req & dataReq & ready;

  // Ready: register ports at once, data port per sequencer
  assign ready      = req & (~dataReq | (state_r == RDB_DONE) |
                      ((state_r == RDB_IDLE) & fastOk));
  assign locked     = (state_r == RDB_LOCK);
  assign refBusy    = (refCnt_r != '0);
  assign xferActive = req & dataReq & ~locked;

  // Next-state decode of the data-port sequencer
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      RDB_IDLE:
        if (req & dataReq & lockReq)
          state_nxt = RDB_LOCK;
        else if (req & dataReq & ~fastOk)
        begin
          state_nxt = RDB_WAIT;
          // Back-to-back normal-acknowledge transfers cost one more cycle; advanced loads one regardless
          cnt_nxt   = advanced ? 2'h1 : WAIT_LD + {1'b0, prevDone_r};
        end
      RDB_WAIT:
        if (!stall)
        begin
          if (cnt_r == 2'h1)
            state_nxt = RDB_DONE;
          cnt_nxt = cnt_r - 2'h1;
        end
      RDB_DONE:
        state_nxt = RDB_IDLE;
      RDB_LOCK:
        state_nxt = RDB_LOCK;
    endcase
    if (hostReset)
      state_nxt = RDB_IDLE;
  end

  // Sequencer registers
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r    <= RDB_IDLE;
      cnt_r      <= 2'h0;
      prevDone_r <= 1'b0;
    end
    else if (ce)
    begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      prevDone_r <= dataDone;
    end
  end

  // Refresh timer and busy counter; an external strobe restarts the busy time
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tmr_r        <= '0;
      refCnt_r     <= '0;
      strobePrev_r <= 1'b0;
    end
    else if (ce)
    begin
      strobePrev_r <= refStrobe;
      tmr_r        <= (refExt | intStart) ? '0 : tmr_r + TW'(1);
      if (refStart)
        refCnt_r <= REF_LOAD;
      else if (refBusy)
        refCnt_r <= refCnt_r - RW'(1);
    end
  end
endmodule
`default_nettype wire

// ### rdb_bus_port.sv
// Host-bus port logic of a plug-in RAM-disk card: port decode, board select,
// write-protect lockout, ready source choice and refresh selection.
// Assumes host and APB inputs synchronous to clock; switches and jumpers are
// held in an APB configuration register.
//
// What this block does
// - Card takes four consecutive I/O ports, answering only inside that block.
// - Six base switches are compared with A7 down to A2.
// - Closed switch wants zero, open wants one; default base is D0 hex.
// - Board answers at its data and address ports only for the board number whose switch is closed.
// - Protected data-port access holds ready low until host reset.
// - Ready comes from normal or advanced acknowledge, chosen by configuration.
// - Advanced acknowledge completes data transfers without wait states unless an internal refresh is running.
// - Normal acknowledge adds two to three wait states per data transfer.
// - Refresh is internal by timer or external by host strobe.
// - External strobe polarity is chosen by configuration.
// - External strobe comes from one of three backplane lines.
// - External refresh never delays host transfers.
// - Internal refresh stalls a colliding transfer until refresh ends.
// - Write-protect control is bit 6 of the upper address port.
// - Access light only during data transfers; select light while selected.
`timescale 1ns/1ps
`default_nettype none
module rdb_bus_port
#(
  parameter int REF_INTERVAL = rdb_pkg::REF_INTERVAL_CYC
)
(
  // Clock, reset, enable
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Host I/O cycle
  input  wire logic        hostReset,
  input  wire logic [7:0]  hostAddr,
  input  wire logic        hostIoRd,
  input  wire logic        hostIoWr,
  input  wire logic [7:0]  hostWrData,
  output logic [7:0]       hostRdData,
  output logic             hostReady,
  // Backplane refresh lines
  input  wire logic [2:0]  hostRefLines,
  // DRAM data path
  input  wire logic [7:0]  memRdData,
  output logic             memWrite,
  output logic [7:0]       memWrData,
  // Indicators
  output logic             accessLed,
  output logic             selectLed
);
  import rdb_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0] cfg_r;
  logic [31:0] prdata_r;
  logic [7:0]  addrHi_r;
  logic [7:0]  addrLo_r;
  logic [2:0]  boardNum_r;
  logic        memWrite_r;
  logic [7:0]  memWrData_r;

  // ----------------------------------------
  // Configuration fields
  // ----------------------------------------
  wire [5:0] baseSwitch  = cfg_r[CFG_BASE_LSB +: 6];
  wire [7:0] boardSwitch = cfg_r[CFG_BOARD_LSB +: 8];
  wire       wpEnable    = cfg_r[CFG_WPEN_BIT];
  wire       advanced    = cfg_r[CFG_ADV_BIT];
  wire       refExt      = cfg_r[CFG_EXT_BIT];
  wire       refPol      = cfg_r[CFG_POL_BIT];
  wire [1:0] refLine     = cfg_r[CFG_LINE_LSB +: 2];

  // ----------------------------------------
  // Host decode
  // ----------------------------------------
  logic       inBlock;
  logic       boardSel;
  logic [1:0] portSel;

  rdb_port_decode u_decode
  (
    .hostAddr    (hostAddr),
    .baseSwitch  (baseSwitch),
    .boardSwitch (boardSwitch),
    .boardNum    (boardNum_r),
    .inBlock     (inBlock),
    .boardSel    (boardSel),
    .portSel     (portSel)
  );

  // Board-number port answers for any card; others need selection
  wire isBoardPort = (portSel == PORT_BOARD);
  wire hit         = inBlock & (isBoardPort | boardSel);
  wire hostReq     = (hostIoRd | hostIoWr) & hit;
  wire dataReq     = (portSel == PORT_DATA);
  wire wpActive    = wpEnable & addrHi_r[WP_BIT];

  // ----------------------------------------
  // Refresh strobe source
  // ----------------------------------------
  // An unassigned line code gives no strobe rather than a random one
  wire lineValid  = (refLine != REF_LINE_NONE);
  wire lineLevel  = lineValid & hostRefLines[refLine];
  wire refStrobe  = lineValid & (refPol ? lineLevel : ~lineLevel);

  // ----------------------------------------
  // Ready sequencer and refresh
  // ----------------------------------------
  logic seqReady;
  logic locked;
  logic refBusy;
  logic xferActive;

  rdb_ready_gen #(.REF_INTERVAL(REF_INTERVAL)) u_ready
  (
    .clock      (clock),
    .rst_b      (rst_b),
    .ce         (ce),
    .hostReset  (hostReset),
    .req        (hostReq),
    .dataReq    (dataReq),
    .advanced   (advanced),
    .lockReq    (wpActive),
    .refExt     (refExt),
    .refStrobe  (refStrobe),
    .ready      (seqReady),
    .locked     (locked),
    .refBusy    (refBusy),
    .xferActive (xferActive)
  );

  // A frozen block never completes a cycle
  assign hostReady = ce & seqReady;
  wire   hostDone  = hostReady & hostReq;
  wire   hostWrEv  = hostDone & hostIoWr;

  // Read mux straight from port registers so zero-wait reads stay valid
  assign hostRdData = (portSel == PORT_DATA)    ? memRdData :
                      (portSel == PORT_ADDR_HI) ? addrHi_r  :
                      (portSel == PORT_ADDR_LO) ? addrLo_r  :
                      {5'h00, boardNum_r};

  // ----------------------------------------
  // Host port registers
  // ----------------------------------------
  // Protect bit survives host reset so data is guarded across power-up
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      addrHi_r   <= 8'h00;
      addrLo_r   <= 8'h00;
      boardNum_r <= 3'h0;
    end
    else if (ce && hostWrEv)
    begin
      if (portSel == PORT_ADDR_HI)
        addrHi_r <= hostWrData;
      if (portSel == PORT_ADDR_LO)
        addrLo_r <= hostWrData;
      if (isBoardPort)
        boardNum_r <= hostWrData[2:0];
    end
  end

  // Data-port write strobe to the DRAM side
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      memWrite_r  <= 1'b0;
      memWrData_r <= 8'h00;
    end
    else if (ce)
    begin
      memWrite_r <= hostWrEv & dataReq;
      if (hostWrEv & dataReq)
        memWrData_r <= hostWrData;
    end
  end

  assign memWrite  = memWrite_r;
  assign memWrData = memWrData_r;

  // ----------------------------------------
  // Indicators
  // ----------------------------------------
  // Select light follows decode of the board number, not host traffic
  assign accessLed = xferActive & hit;
  assign selectLed = boardSel;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  wire apbSetup  = psel & ~penable;
  wire apbAccess = psel & penable;
  wire cfgHit    = (paddr == CFG_OFS);
  wire statHit   = (paddr == STAT_OFS);
  wire mapped    = cfgHit | statHit;

  wire [31:0] statusWord =
    (32'(boardNum_r) << ST_BOARD_LSB) |
    (32'(addrLo_r)   << ST_LO_LSB)    |
    (32'(addrHi_r)   << ST_HI_LSB)    |
    (32'(refBusy)    << ST_REF_BIT)   |
    (32'(wpActive)   << ST_WP_BIT)    |
    (32'(boardSel)   << ST_SEL_BIT)   |
    (32'(locked)     << ST_LOCK_BIT);

  wire [31:0] readMux = cfgHit  ? cfg_r      :
                        statHit ? statusWord : 32'h0000_0000;

  // Zero-wait slave; data is captured in setup and held through access
  assign pready  = ce;
  assign pslverr = apbAccess & ~mapped;
  assign prdata  = prdata_r;

  // Configuration register write; reserved bits stay zero
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      cfg_r <= CFG_RESET;
    else if (ce && apbAccess && pwrite && cfgHit)
      cfg_r <= pwdata & CFG_MASK;
  end

  // Read data register
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      prdata_r <= 32'h0000_0000;
    else if (ce && apbSetup && !pwrite)
      prdata_r <= readMux;
  end
endmodule
`default_nettype wire

// ### rdb_host_model.sv
// Host processor model: runs I/O cycles at the card's backplane port.
// Assumes one clock shared with the card; ready sampled on rising edges.
`timescale 1ns/1ps
`default_nettype none
module rdb_host_model
(
  // Clock and answer
  input  wire logic      clock,
  input  wire logic      hostReady,
  // I/O cycle
  output var logic [7:0] hostAddr,
  output var logic       hostIoRd,
  output var logic       hostIoWr,
  output var logic [7:0] hostWrData
);
  // ------------------------------
  // Cycle driver
  // ------------------------------
  initial
  begin
    {hostAddr, hostIoRd, hostIoWr, hostWrData} = 18'h0;
  end
  // Gives up after 20 waits, since a hung card needs a reset anyway
  task automatic io(input logic w, input logic [7:0] a, input logic [7:0] d, output int n);
    n = 0;
    @(posedge clock);
    hostAddr   <= a;
    hostWrData <= d;
    hostIoWr   <= w;
    hostIoRd   <= !w;
    @(posedge clock);
    while (hostReady !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clock);
    end
    // Released lines must not keep their last value
    hostIoRd   <= 1'b0;
    hostIoWr   <= 1'b0;
    hostAddr   <= ~a;
    hostWrData <= ~d;
  endtask
endmodule
`default_nettype wire

// ### rdb_bus_port_asserts.sv
// Checker for the RAM-disk bus port, bound to the top module's ports.
// Assumes APB and host inputs change only just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module rdb_bus_port_chk
#(
  parameter int REF_INTERVAL = rdb_pkg::REF_INTERVAL_CYC
)
(
  // Clock, reset, enable
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        ce,
  // APB
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Host side
  input wire logic [7:0]  hostAddr,
  input wire logic        hostIoRd,
  input wire logic        hostIoWr,
  input wire logic [7:0]  hostWrData,
  input wire logic        hostReady,
  input wire logic        memWrite,
  input wire logic [7:0]  memWrData,
  input wire logic        accessLed,
  input wire logic        selectLed
);
  import rdb_pkg::*;
  logic [31:0] cfgSh_r;
  logic        wpSh_r;
  logic [2:0]  brdSh_r;
  // ------------------------------
  // Expected decode from shadowed settings
  // ------------------------------
  wire logic inBlk  = (hostIoRd || hostIoWr) && hostAddr[7:2] == cfgSh_r[5:0];
  wire logic hostWr = hostIoWr && hostReady && inBlk;
  wire logic dReq   = inBlk && hostAddr[1:0] == PORT_DATA && selectLed;
  wire logic dWr    = hostWr && hostAddr[1:0] == PORT_DATA;
  wire logic lockOn = cfgSh_r[CFG_WPEN_BIT] && wpSh_r;
  wire logic adv    = cfgSh_r[CFG_ADV_BIT];
  wire logic ext    = cfgSh_r[CFG_EXT_BIT];
  wire logic regOk  = inBlk && hostAddr[1:0] != PORT_DATA && (selectLed || hostAddr[1:0] == PORT_BOARD);
  // Shadows follow completed writes only, so refused cycles leave them alone
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfgSh_r <= CFG_RESET;
      wpSh_r  <= 1'b0;
      brdSh_r <= 3'h0;
    end
    else
    begin
      if (psel && penable && pready && pwrite && paddr == CFG_OFS)
        cfgSh_r <= pwdata & CFG_MASK;
      if (hostWr && hostAddr[1:0] == PORT_ADDR_HI)
        wpSh_r <= hostWrData[WP_BIT];
      if (hostWr && hostAddr[1:0] == PORT_BOARD)
        brdSh_r <= hostWrData[2:0];
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  a_ready_cause: assert property (hostReady |-> inBlk && ce)
    else $error("host ready outside the block");
  a_board_gate: assert property (selectLed == !cfgSh_r[CFG_BOARD_LSB + brdSh_r])
    else $error("board select wrong");
  a_reg_nowait: assert property (regOk && ce |-> hostReady)
    else $error("register port not answered");
  a_lock_hold: assert property (dReq && lockOn |-> !hostReady)
    else $error("protected access answered");
  a_adv_nowait: assert property (dReq && ce && adv && ext && !lockOn |-> hostReady)
    else $error("advanced transfer waited");
  a_normal_waits: assert property ($rose(dReq) && !adv && ext && !lockOn && ce
    |-> !hostReady ##1 !hostReady ##[1:2] hostReady) else $error("normal wait count wrong");
  a_stall_bound: assert property ($rose(dReq) && !ext && !lockOn && ce |-> ##[0:12] hostReady)
    else $error("refresh stall too long");
  a_mem_write: assert property (memWrite == $past(dWr)
    && (!memWrite || memWrData == $past(hostWrData)))
    else $error("data write pulse wrong");
  a_access_led: assert property ((accessLed |-> dReq) and (dReq && !lockOn |-> accessLed))
    else $error("access light off a transfer");
  a_apb_answer: assert property (psel && penable |-> pready == ce
    && pslverr == !(paddr == CFG_OFS || paddr == STAT_OFS)) else $error("apb answer wrong");
  c_adv_xfer: cover property (dReq && adv && hostReady);
  c_locked: cover property (dReq && lockOn);
  c_int_stall: cover property ($rose(dReq) && !ext ##[4:12] hostReady);
endmodule
bind rdb_bus_port rdb_bus_port_chk #(.REF_INTERVAL(REF_INTERVAL)) u_chk
(
  .clock, .rst_b, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .pslverr,
  .hostAddr, .hostIoRd, .hostIoWr, .hostWrData, .hostReady, .memWrite, .memWrData,
  .accessLed, .selectLed
);
`default_nettype wire

// ### rdb_bus_port_tb_top.sv
// Self-checking bench for the RAM-disk bus port: APB set-up and host cycles.
// Assumes the checker is bound in and the host model runs the I/O cycles.
`timescale 1ns/1ps
`default_nettype none
module rdb_bus_port_tb_top;
  import rdb_pkg::*;
  logic        clock = 1'b0, rst_b = 1'b0, ce = 1'b1, hostReset = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, memRdData = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [2:0]  hostRefLines = 3'h0;
  logic        pready, pslverr, hostReady, hostIoRd, hostIoWr, memWrite, accessLed, selectLed;
  logic [7:0]  hostAddr, hostWrData, hostRdData, memWrData;
  logic [32:0] expQ[$];
  int          bad_count = 0, checks = 0, cyc = 0, seed = 81;
  always #25 clock = ~clock;
  rdb_bus_port #(.REF_INTERVAL(20)) dut
  (
    .clock, .rst_b, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .hostReset, .hostAddr, .hostIoRd, .hostIoWr, .hostWrData, .hostRdData, .hostReady,
    .hostRefLines, .memRdData, .memWrite, .memWrData, .accessLed, .selectLed
  );
  rdb_host_model host (.clock, .hostReady, .hostAddr, .hostIoRd, .hostIoWr, .hostWrData);
  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic complete_run;
    if (bad_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [32:0] s, input logic [32:0] e);
    checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // APB transfer held until pready; a read notes {pslverr, prdata} expected
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    if (!w)
      expQ.push_back(e);
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Settle time after a change lets any running refresh finish first
  task automatic setcfg(input logic [5:0] b, input logic [7:0] s, input logic [5:0] f);
    apb(1'b1, CFG_OFS, {10'h0, f, s, 2'h0, b}, 33'h0);
    repeat (6) @(posedge clock);
  endtask
  task automatic hio(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e, output int n);
    if (!w)
      expQ.push_back({25'h0, e});
    host.io(w, a, d, n);
  endtask
  // Result watcher: oldest note against each completed read
  always @(posedge clock)
  begin
    hostRefLines <= 3'($random(seed));
    if ((psel && penable && pready === 1'b1 && !pwrite) || (hostReady === 1'b1 && hostIoRd))
    begin
      if (expQ.size() == 0)
        check("spare result", 33'h0, 33'h1);
      else
        check("read data", psel ? {pslverr, prdata} : {25'h0, hostRdData}, expQ.pop_front());
    end
  end
  // Hang guard
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      bad_count++;
      complete_run;
    end
  end
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial
  begin : mainSeq
    int i, n;
    logic [5:0] b;
    logic [7:0] d;
    logic [31:0] r;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    apb(1'b0, CFG_OFS, 32'h0, {1'b0, CFG_RESET});
    apb(1'b0, 8'h08, 32'h0, 33'h1_0000_0000);
    r = $random(seed);
    apb(1'b1, CFG_OFS, r, 33'h0);
    apb(1'b0, CFG_OFS, 32'h0, {1'b0, r & CFG_MASK});
    // Bases: a good write and read-back, one write with a single address bit off
    for (i = 0; i < 4; i++)
    begin
      b = (i == 0) ? 6'h34 : 6'($random(seed));
      setcfg(b, 8'hFE, 6'h1E);
      d = 8'($random(seed));
      hio(1'b1, {b, PORT_ADDR_LO}, d, 8'h00, n);
      hio(1'b1, {b ^ (6'h01 << i), PORT_ADDR_LO}, ~d, 8'h00, n);
      check("outside block", 33'(n), 33'h14);
      hio(1'b0, {b, PORT_ADDR_LO}, 8'h00, d, n);
    end
    // Every board number, first a wrong one
    for (i = 0; i < 8; i++)
    begin
      setcfg(b, ~(8'h01 << i), 6'h1E);
      hio(1'b1, {b, PORT_BOARD}, 8'(i + 1), 8'h00, n);
      hio(1'b1, {b, PORT_ADDR_LO}, 8'h5A, 8'h00, n);
      check("unselected", 33'(n), 33'h14);
      hio(1'b1, {b, PORT_BOARD}, 8'(i), 8'h00, n);
      // The board number lands at the completing edge; look one edge later
      @(posedge clock);
      check("select light", {32'h0, selectLed}, 33'h1);
    end
    // Advanced ready over each strobe line and polarity
    for (i = 0; i < 6; i++)
    begin
      setcfg(b, 8'h7F, {2'(i % 3), i[2], 3'h6});
      d = 8'($random(seed));
      memRdData <= d;
      hio(i[0], {b, PORT_DATA}, d, d, n);
      check("advanced waits", 33'(n), 33'h0);
    end
    setcfg(b, 8'h7F, 6'h1C);
    for (i = 0; i < 4; i++)
    begin
      memRdData <= 8'(i);
      hio(i[0], {b, PORT_DATA}, 8'(i), 8'(i), n);
      check("normal waits", 33'(n >= 2 && n <= 3), 33'h1);
    end
    // Internal refresh collides with back-to-back reads
    setcfg(b, 8'h7F, 6'h00);
    for (i = 0; i < 24; i++)
    begin
      memRdData <= 8'(i);
      hio(1'b0, {b, PORT_DATA}, 8'h00, 8'(i), n);
      check("stall bound", 33'(n <= 9), 33'h1);
    end
    // Protect bit set: harmless until protection is enabled
    hio(1'b1, {b, PORT_ADDR_HI}, 8'h40, 8'h00, n);
    hio(1'b0, {b, PORT_DATA}, 8'h00, memRdData, n);
    check("protect off", 33'(n >= 2 && n <= 9), 33'h1);
    setcfg(b, 8'h7F, 6'h07);
    hio(1'b1, {b, PORT_DATA}, 8'hA5, 8'h00, n);
    check("locked", 33'(n), 33'h14);
    hostReset <= 1'b1;
    @(posedge clock);
    hostReset <= 1'b0;
    hio(1'b1, {b, PORT_ADDR_HI}, 8'h00, 8'h00, n);
    hio(1'b0, {b, PORT_DATA}, 8'h00, memRdData, n);
    check("unlocked", 33'(n), 33'h0);
    repeat (4) @(posedge clock);
    // A read that never completed would leave its note behind
    check("pending notes", 33'(expQ.size()), 33'h0);
    complete_run;
  end
endmodule
`default_nettype wire
